// file: core/t3rsc_pkg.sv
// Shared constants and types for the reload/split/capture timer
package t3rsc_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RLD_LO = 8'h04;
	localparam logic [7:0] OFF_RLD_HI = 8'h08;
	localparam logic [7:0] OFF_CNT_LO = 8'h0c;
	localparam logic [7:0] OFF_CNT_HI = 8'h10;
	localparam logic [7:0] OFF_CLKCTL = 8'h14;
	localparam logic [7:0] OFF_IE = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1c;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CLK_LO_BIT = 0;
	localparam int CLK_HI_BIT = 1;
	localparam int IE_BIT = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hfd;
	localparam logic [7:0] BYTE_MAX = 8'hff;
	localparam logic [15:0] WORD_MAX = 16'hffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Timing counts
	// ****************************************
	localparam logic [3:0] SYS_DIV_LAST = 4'hb;
	localparam logic [2:0] EXT_DIV_LAST = 3'h7;
	localparam logic [1:0] SYNC_TIMER_CLKS = 2'h3;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic hi_flag;
		logic lo_flag;
		logic lo_ie;
		logic cap_en;
		logic split;
		logic run;
		logic unused;
		logic xclk;
	} t3rsc_ctrl_t;

	typedef struct packed {
		logic sys12;
		logic ext_sync;
		logic ext_direct;
	} t3rsc_tick_t;

	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} t3rsc_wr_t;

endpackage : t3rsc_pkg

// file: core/t3rsc_tick.sv
// Timer clock prescalers: system/12 and external/8 ticks
`timescale 1ns/1ps
module t3rsc_tick (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ext_osc_in,
	output t3rsc_pkg::t3rsc_tick_t tick
);
	logic [3:0] pre12_r;
	logic ext_prev_r;
	logic [2:0] ext_cnt_r;
	logic sync1_r;
	logic sync2_r;
	logic sync3_r;

	wire ext_rise = ext_osc_in & ~ext_prev_r;
	wire pre12_wrap = pre12_r == t3rsc_pkg::SYS_DIV_LAST;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre12_r <= 4'h0;
			ext_prev_r <= 1'b0;
			ext_cnt_r <= 3'h0;
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			pre12_r <= pre12_wrap ? 4'h0 : pre12_r + 4'h1;
			ext_prev_r <= ext_osc_in;
			ext_cnt_r <= ext_rise ? ext_cnt_r + 3'h1 : ext_cnt_r;
			sync1_r <= ext_cnt_r[2];
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// Direct tick bypasses the resynchroniser; edge taken after second stage
	assign tick.sys12 = pre12_wrap;
	assign tick.ext_direct = ext_rise & (ext_cnt_r == t3rsc_pkg::EXT_DIV_LAST);
	assign tick.ext_sync = sync2_r & ~sync3_r;

endmodule : t3rsc_tick

// file: core/t3rsc_axil.sv
// AXI4-Lite slave front end for the timer byte registers
`timescale 1ns/1ps
module t3rsc_axil (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output t3rsc_pkg::t3rsc_wr_t wr,
	input wire logic wr_hit,
	output logic [7:0] rd_addr,
	input wire logic rd_hit,
	input wire logic [7:0] rd_data
);
	logic aw_have_r;
	logic [7:0] aw_addr_r;
	logic w_have_r;
	logic [7:0] w_data_r;
	logic w_lane0_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire do_wr = aw_have_r & w_have_r & ~bvalid_r;
	wire ar_take = s_axi_arvalid & s_axi_arready;

	assign s_axi_awready = ~aw_have_r & ~bvalid_r;
	assign s_axi_wready = ~w_have_r & ~bvalid_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign rd_addr = s_axi_araddr;
	// Only byte lane 0 carries register bits
	assign wr.we = do_wr & wr_hit & w_lane0_r;
	assign wr.addr = aw_addr_r;
	assign wr.data = w_data_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_have_r <= 1'b0;
			w_data_r <= 8'h00;
			w_lane0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= t3rsc_pkg::RESP_OKAY;
		end else begin
			aw_have_r <= aw_take | (aw_have_r & ~do_wr);
			w_have_r <= w_take | (w_have_r & ~do_wr);
			aw_addr_r <= aw_take ? s_axi_awaddr : aw_addr_r;
			w_data_r <= w_take ? s_axi_wdata[7:0] : w_data_r;
			w_lane0_r <= w_take ? s_axi_wstrb[0] : w_lane0_r;
			bvalid_r <= do_wr | (bvalid_r & ~s_axi_bready);
			bresp_r <= do_wr ? (wr_hit ? t3rsc_pkg::RESP_OKAY : t3rsc_pkg::RESP_SLVERR) : bresp_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= t3rsc_pkg::RESP_OKAY;
		end else begin
			rvalid_r <= ar_take | (rvalid_r & ~s_axi_rready);
			rdata_r <= ar_take ? {24'h00_0000, rd_hit ? rd_data : 8'h00} : rdata_r;
			rresp_r <= ar_take ? (rd_hit ? t3rsc_pkg::RESP_OKAY : t3rsc_pkg::RESP_SLVERR) : rresp_r;
		end
	end

endmodule : t3rsc_axil

// file: core/t3rsc_timer.sv
// Timer core: 16-bit or split 8-bit auto-reload counter with capture
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

module t3rsc_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_osc_in,
	input wire logic cmp_in,
	input wire logic suspend_in,
	output logic irq,
	output logic wake,
	output logic sync_pending_status
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == t3rsc_pkg::OFF_CTRL) || (a == t3rsc_pkg::OFF_RLD_LO) ||
			(a == t3rsc_pkg::OFF_RLD_HI) || (a == t3rsc_pkg::OFF_CNT_LO) ||
			(a == t3rsc_pkg::OFF_CNT_HI) || (a == t3rsc_pkg::OFF_CLKCTL) ||
			(a == t3rsc_pkg::OFF_IE) || (a == t3rsc_pkg::OFF_STAT);
	endfunction : reg_hit

	function automatic logic clk_pick(input logic sel, input logic xsel,
		input t3rsc_pkg::t3rsc_tick_t t, input logic susp);
		if (sel) begin
			clk_pick = 1'b1;
		end else if (xsel) begin
			clk_pick = susp ? t.ext_direct : t.ext_sync;
		end else begin
			clk_pick = t.sys12;
		end
	endfunction : clk_pick

	// ****************************************
	// State
	// ****************************************
	t3rsc_pkg::t3rsc_ctrl_t ctrl_r;
	t3rsc_pkg::t3rsc_ctrl_t ctrl_nxt;
	t3rsc_pkg::t3rsc_wr_t wr;
	t3rsc_pkg::t3rsc_tick_t tick;
	logic [7:0] reload_low_byte_r;
	logic [7:0] reload_high_byte_r;
	logic [7:0] count_low_byte_r;
	logic [7:0] count_high_byte_r;
	logic [7:0] reload_low_byte_nxt;
	logic [7:0] reload_high_byte_nxt;
	logic [7:0] count_low_byte_nxt;
	logic [7:0] count_high_byte_nxt;
	logic low_byte_clock_select_r;
	logic high_byte_clock_select_r;
	logic timer_ie_r;
	logic cmp_prev_r;
	logic susp_prev_r;
	logic woke_r;
	logic wake_r;
	logic pend_r;
	logic [1:0] pend_cnt_r;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;

	// ****************************************
	// Bus and prescalers
	// ****************************************
	t3rsc_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr(wr),
		.wr_hit(reg_hit(wr.addr)),
		.rd_addr(rd_addr),
		.rd_hit(reg_hit(rd_addr)),
		.rd_data(rd_data)
	);

	t3rsc_tick u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.ext_osc_in(ext_osc_in),
		.tick(tick)
	);

	// ****************************************
	// Write decode
	// ****************************************
	wire wr_ctrl = wr.we && wr.addr == t3rsc_pkg::OFF_CTRL;
	// Timer bytes are locked while resynchronising after wake
	wire wr_rll = wr.we && !pend_r && wr.addr == t3rsc_pkg::OFF_RLD_LO;
	wire wr_rlh = wr.we && !pend_r && wr.addr == t3rsc_pkg::OFF_RLD_HI;
	wire wr_cl = wr.we && !pend_r && wr.addr == t3rsc_pkg::OFF_CNT_LO;
	wire wr_ch = wr.we && !pend_r && wr.addr == t3rsc_pkg::OFF_CNT_HI;
	wire wr_clk = wr.we && wr.addr == t3rsc_pkg::OFF_CLKCTL;
	wire wr_ie = wr.we && wr.addr == t3rsc_pkg::OFF_IE;
	wire cnt_wr = wr_cl | wr_ch;

	// ****************************************
	// Mode and clock selection
	// ****************************************
	wire cap_mode = ctrl_r.cap_en & ~ctrl_r.split;
	wire xclk_eff = ctrl_r.xclk & ~cap_mode;
	wire lo_tk = clk_pick(low_byte_clock_select_r, xclk_eff, tick, suspend_in);
	wire hi_tk = clk_pick(high_byte_clock_select_r, xclk_eff, tick, suspend_in);

	// ****************************************
	// Counting
	// ****************************************
	wire [15:0] cnt16 = {count_high_byte_r, count_low_byte_r};
	wire lo_max = count_low_byte_r == t3rsc_pkg::BYTE_MAX;
	wire hi_max = count_high_byte_r == t3rsc_pkg::BYTE_MAX;
	wire inc16 = ~ctrl_r.split & ctrl_r.run & lo_tk;
	wire wrap16 = inc16 & (cnt16 == t3rsc_pkg::WORD_MAX);
	wire lo_step = ctrl_r.split ? lo_tk : inc16;
	wire hi_step = ctrl_r.split & ctrl_r.run & hi_tk;
	wire lo_wrap = lo_step & lo_max;
	wire hi_wrap_split = hi_step & hi_max;
	wire cmp_rise = cmp_in & ~cmp_prev_r;
	wire cap_ev = cap_mode & cmp_rise;
	wire hi_set = wrap16 | hi_wrap_split | cap_ev;
	wire ovf_ev = wrap16 | hi_wrap_split;

	assign count_low_byte_nxt = wr_cl ? wr.data :
		!lo_step ? count_low_byte_r :
		(ctrl_r.split ? lo_max : wrap16) ? reload_low_byte_r :
		count_low_byte_r + 8'h01;
	assign count_high_byte_nxt = wr_ch ? wr.data :
		hi_step ? (hi_max ? reload_high_byte_r : count_high_byte_r + 8'h01) :
		wrap16 ? reload_high_byte_r :
		(inc16 & lo_max) ? count_high_byte_r + 8'h01 :
		count_high_byte_r;
	assign reload_low_byte_nxt = wr_rll ? wr.data :
		cap_ev ? count_low_byte_r : reload_low_byte_r;
	assign reload_high_byte_nxt = wr_rlh ? wr.data :
		cap_ev ? count_high_byte_r : reload_high_byte_r;

	// ****************************************
	// Control register, hardware sets win
	// ****************************************
	always_comb begin
		ctrl_nxt = wr_ctrl ? t3rsc_pkg::t3rsc_ctrl_t'(wr.data & t3rsc_pkg::CTRL_WMASK) : ctrl_r;
		ctrl_nxt.unused = 1'b0;
		ctrl_nxt.hi_flag = hi_set | ctrl_nxt.hi_flag;
		ctrl_nxt.lo_flag = lo_wrap | ctrl_nxt.lo_flag;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= t3rsc_pkg::t3rsc_ctrl_t'(t3rsc_pkg::RST_BYTE);
			reload_low_byte_r <= t3rsc_pkg::RST_BYTE;
			reload_high_byte_r <= t3rsc_pkg::RST_BYTE;
			count_low_byte_r <= t3rsc_pkg::RST_BYTE;
			count_high_byte_r <= t3rsc_pkg::RST_BYTE;
			low_byte_clock_select_r <= 1'b0;
			high_byte_clock_select_r <= 1'b0;
			timer_ie_r <= 1'b0;
			cmp_prev_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			reload_low_byte_r <= reload_low_byte_nxt;
			reload_high_byte_r <= reload_high_byte_nxt;
			count_low_byte_r <= count_low_byte_nxt;
			count_high_byte_r <= count_high_byte_nxt;
			low_byte_clock_select_r <= wr_clk ? wr.data[t3rsc_pkg::CLK_LO_BIT] :
				low_byte_clock_select_r;
			high_byte_clock_select_r <= wr_clk ? wr.data[t3rsc_pkg::CLK_HI_BIT] :
				high_byte_clock_select_r;
			timer_ie_r <= wr_ie ? wr.data[t3rsc_pkg::IE_BIT] : timer_ie_r;
			cmp_prev_r <= cmp_in;
		end
	end

	// ****************************************
	// Suspend wake and resync window
	// ****************************************
	wire susp_exit = susp_prev_r & ~suspend_in;
	wire pend_done = pend_r & lo_tk & (pend_cnt_r == t3rsc_pkg::SYNC_TIMER_CLKS - 2'h1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			susp_prev_r <= 1'b0;
			woke_r <= 1'b0;
			wake_r <= 1'b0;
			pend_r <= 1'b0;
			pend_cnt_r <= 2'h0;
		end else begin
			susp_prev_r <= suspend_in;
			wake_r <= suspend_in & ovf_ev;
			woke_r <= (suspend_in & ovf_ev) | (woke_r & ~(suspend_in & ~susp_prev_r));
			pend_r <= (susp_exit & ~woke_r) | (pend_r & ~pend_done);
			pend_cnt_r <= (susp_exit | pend_done) ? 2'h0 :
				(pend_r & lo_tk) ? pend_cnt_r + 2'h1 : pend_cnt_r;
		end
	end

	// ****************************************
	// Outputs and readback
	// ****************************************
	assign irq = timer_ie_r & (ctrl_r.hi_flag | (ctrl_r.lo_ie & ctrl_r.lo_flag));
	assign wake = wake_r;
	assign sync_pending_status = pend_r;

	wire [7:0] rd_clk = {6'h00, high_byte_clock_select_r, low_byte_clock_select_r};
	wire [7:0] rd_stat = {5'h00, woke_r, susp_prev_r, pend_r};
	assign rd_data = (rd_addr == t3rsc_pkg::OFF_CTRL) ? ctrl_r :
		(rd_addr == t3rsc_pkg::OFF_RLD_LO) ? reload_low_byte_r :
		(rd_addr == t3rsc_pkg::OFF_RLD_HI) ? reload_high_byte_r :
		(rd_addr == t3rsc_pkg::OFF_CNT_LO) ? count_low_byte_r :
		(rd_addr == t3rsc_pkg::OFF_CNT_HI) ? count_high_byte_r :
		(rd_addr == t3rsc_pkg::OFF_CLKCTL) ? rd_clk :
		(rd_addr == t3rsc_pkg::OFF_IE) ? {7'h00, timer_ie_r} :
		(rd_addr == t3rsc_pkg::OFF_STAT) ? rd_stat : 8'h00;

	// ****************************************
	// Checks
	// ****************************************
	chk_wrap_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		wrap16 && !cnt_wr |=> cnt16 == $past({reload_high_byte_r, reload_low_byte_r})
		&& ctrl_r.hi_flag)
		else $error("16-bit wrap did not reload or flag");
	chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_r.hi_flag && !wr_ctrl |=> ctrl_r.hi_flag)
		else $error("high flag cleared without a write");
	chk_low_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		lo_wrap |=> ctrl_r.lo_flag)
		else $error("low wrap did not set low flag");
	chk_split_low_free: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_r.split && !ctrl_r.run && lo_tk && !lo_max && !cnt_wr
		|=> count_low_byte_r == $past(count_low_byte_r) + 8'h01)
		else $error("split low byte did not count while stopped");
	chk_split_hi_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_r.split && !ctrl_r.run && !cnt_wr |=> $stable(count_high_byte_r))
		else $error("split high byte moved with run clear");
	chk_capture_copy: assert property (@(posedge aclk) disable iff (!aresetn)
		cap_ev && !wr_rll && !wr_rlh
		|=> {reload_high_byte_r, reload_low_byte_r} == $past(cnt16) && ctrl_r.hi_flag)
		else $error("capture did not copy count");
	chk_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		timer_ie_r && hi_set && !wr_ie |=> irq)
		else $error("enabled overflow did not raise interrupt");
	chk_wake_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		suspend_in && ovf_ev |=> wake ##1 !wake)
		else $error("wake not a single pulse after overflow");
	chk_pend_start: assert property (@(posedge aclk) disable iff (!aresetn)
		susp_exit && !woke_r |=> sync_pending_status)
		else $error("pending status not raised on foreign wake");
	chk_cap_clock: assert property (@(posedge aclk) disable iff (!aresetn)
		cap_mode && !low_byte_clock_select_r |-> lo_tk == tick.sys12)
		else $error("capture mode used external clock");

endmodule : t3rsc_timer

// file: sim/t3rsc_far_model.sv
// Far side of the timer: external oscillator and comparator output
`timescale 1ns/1ps
module t3rsc_far_model (
	input wire logic cmp_req,
	output logic ext_osc_in,
	output logic cmp_in
);
	// ****************************************
	// Oscillator, free running, edges clear of aclk rising edges
	// ****************************************
	initial ext_osc_in = 1'b0;
	always #80 ext_osc_in = ~ext_osc_in;
	// ****************************************
	// Comparator follows request with analog delay, edges far apart
	// ****************************************
	initial cmp_in = 1'b0;
	always @(cmp_req) cmp_in <= #37 cmp_req;
endmodule : t3rsc_far_model

// file: sim/tb.sv
// Self-checking bench for the reload/split/capture timer
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] A_CTL = t3rsc_pkg::OFF_CTRL;
	localparam logic [7:0] A_RLO = t3rsc_pkg::OFF_RLD_LO;
	localparam logic [7:0] A_RHI = t3rsc_pkg::OFF_RLD_HI;
	localparam logic [7:0] A_CLO = t3rsc_pkg::OFF_CNT_LO;
	localparam logic [7:0] A_CHI = t3rsc_pkg::OFF_CNT_HI;
	localparam logic [7:0] A_CLK = t3rsc_pkg::OFF_CLKCTL;
	localparam logic [7:0] A_IE = t3rsc_pkg::OFF_IE;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic suspend_in = 1'b0, cmp_req = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, ext_osc_in, cmp_in, irq, wake, sync_pend;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, d;
	int mismatches = 0;
	int comparisons = 0;
	always #10 aclk = ~aclk;
	t3rsc_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_osc_in(ext_osc_in), .cmp_in(cmp_in),
		.suspend_in(suspend_in), .irq(irq), .wake(wake), .sync_pending_status(sync_pend));
	t3rsc_far_model far (.cmp_req(cmp_req), .ext_osc_in(ext_osc_in), .cmp_in(cmp_in));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				done = 1'b1;
				bready <= 1'b0;
				chk({30'h0, bresp}, {30'h0, er});
			end
		end
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				done = 1'b1;
				v = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
	endtask : axr
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [1:0] r;
		axr(a, d, r);
		chk(d, {24'h0, exp});
		chk({30'h0, r}, {30'h0, t3rsc_pkg::RESP_OKAY});
	endtask : rdchk
	task automatic w(input logic [7:0] a, input logic [7:0] v);
		axw(a, v, t3rsc_pkg::RESP_OKAY);
	endtask : w
	task automatic wait_irq(input logic v, input int lim);
		int n;
		n = 0;
		while (irq !== v && n < lim) begin
			@(posedge aclk);
			n++;
		end
	endtask : wait_irq
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		logic [1:0] r;
		for (int i = 0; i < 5; i++) rdchk(8'(4 * i), 8'h00);
		w(A_CTL, 8'h02);
		rdchk(A_CTL, 8'h00);
		axw(8'h40, 8'h55, t3rsc_pkg::RESP_SLVERR);
		axr(8'h40, d, r);
		chk({r, d[7:0]}, {t3rsc_pkg::RESP_SLVERR, 8'h00});
		$display("test reset done");
	endtask : t_reset
	task automatic t_wrap16();
		w(A_CHI, 8'hff);
		w(A_CLO, 8'hf0);
		w(A_RHI, 8'h12);
		w(A_RLO, 8'h34);
		w(A_IE, 8'h01);
		w(A_CLK, 8'h03);
		w(A_CTL, 8'h04);
		wait_irq(1'b1, 60);
		chk(irq, 1'b1);
		rdchk(A_CTL, 8'hc4);
		rdchk(A_CHI, 8'h12);
		repeat (10) @(posedge aclk);
		chk(irq, 1'b1);
		w(A_CTL, 8'h00);
		chk(irq, 1'b0);
		$display("test wrap16 done");
	endtask : t_wrap16
	task automatic t_lowirq();
		w(A_CHI, 8'h00);
		w(A_CLO, 8'hf0);
		w(A_CTL, 8'h24);
		wait_irq(1'b1, 60);
		chk(irq, 1'b1);
		rdchk(A_CTL, 8'h64);
		w(A_CTL, 8'h00);
		chk(irq, 1'b0);
		$display("test lowirq done");
	endtask : t_lowirq
	task automatic t_split();
		logic [1:0] r;
		w(A_CHI, 8'hf0);
		w(A_RLO, 8'hf8);
		w(A_RHI, 8'ha0);
		w(A_CLO, 8'hf8);
		w(A_CTL, 8'h08);
		repeat (30) @(posedge aclk);
		rdchk(A_CHI, 8'hf0);
		rdchk(A_CTL, 8'h48);
		chk(irq, 1'b0);
		axr(A_CLO, d, r);
		chk(d >= 32'hf8 && d <= 32'hff, 1'b1);
		w(A_CTL, 8'h0c);
		wait_irq(1'b1, 60);
		chk(irq, 1'b1);
		axr(A_CHI, d, r);
		chk(d >= 32'ha0 && d <= 32'hb0, 1'b1);
		w(A_CTL, 8'h00);
		$display("test split done");
	endtask : t_split
	task automatic t_capture();
		w(A_CLK, 8'h00);
		w(A_CHI, 8'h56);
		w(A_CLO, 8'h00);
		w(A_CTL, 8'h18);
		cmp_req <= 1'b1;
		repeat (10) @(posedge aclk);
		cmp_req <= 1'b0;
		repeat (10) @(posedge aclk);
		rdchk(A_RHI, 8'ha0);
		rdchk(A_CTL, 8'h18);
		w(A_CTL, 8'h14);
		cmp_req <= 1'b1;
		wait_irq(1'b1, 20);
		chk(irq, 1'b1);
		rdchk(A_RHI, 8'h56);
		rdchk(A_CTL, 8'h94);
		cmp_req <= 1'b0;
		w(A_CTL, 8'h00);
		$display("test capture done");
	endtask : t_capture
	task automatic t_div12();
		logic [1:0] r;
		w(A_CLO, 8'h00);
		w(A_CTL, 8'h04);
		repeat (238) @(posedge aclk);
		w(A_CTL, 8'h00);
		axr(A_CLO, d, r);
		chk(d >= 32'd19 && d <= 32'd21, 1'b1);
		$display("test div12 done");
	endtask : t_div12
	task automatic t_suspend();
		logic seen;
		logic [1:0] r;
		logic [7:0] e;
		seen = 1'b0;
		w(A_CHI, 8'hff);
		w(A_CLO, 8'hfe);
		suspend_in <= 1'b1;
		w(A_CTL, 8'h05);
		repeat (400) begin
			@(posedge aclk);
			if (wake === 1'b1) seen = 1'b1;
		end
		chk(seen, 1'b1);
		rdchk(A_CTL, 8'hc5);
		suspend_in <= 1'b0;
		repeat (5) @(posedge aclk);
		chk(sync_pend, 1'b0);
		rdchk(t3rsc_pkg::OFF_STAT, 8'h04);
		axr(A_CLO, d, r);
		e = d[7:0];
		repeat (150) @(posedge aclk);
		axr(A_CLO, d, r);
		chk(d[7:0] - e >= 8'h02 && d[7:0] - e <= 8'h03, 1'b1);
		w(A_CTL, 8'h00);
		$display("test suspend done");
	endtask : t_suspend
	task automatic t_sync();
		int n;
		n = 0;
		w(A_CLK, 8'h01);
		suspend_in <= 1'b1;
		repeat (3) @(posedge aclk);
		suspend_in <= 1'b0;
		repeat (4) if (sync_pend !== 1'b1) @(posedge aclk);
		chk(sync_pend, 1'b1);
		while (sync_pend === 1'b1 && n < 20) begin
			@(posedge aclk);
			n++;
		end
		chk(n >= 2 && n <= 4, 1'b1);
		$display("test sync done");
	endtask : t_sync
	// ****************************************
	// Run control
	// ****************************************
	task automatic report_and_stop();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#(20 * 20000);
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_wrap16();
		t_lowirq();
		t_split();
		t_capture();
		t_div12();
		t_suspend();
		t_sync();
		report_and_stop();
	end
endmodule : tb
